// [verilog/dtio_top.sv]
// dtio_top: terminal conditioning for analog inputs, digital input polarity
// and change delays, and function routing to collector and relay outputs.
// assumes an apb master on sys_clk_i and drive state flags on the same clock.
// Operation
// [R01] below minimum: digit 0 gives minimum point value, digit 1 gives zero
// [R02] policy digits: voltage, current, third input; default all zero
// [R03] forward, reverse, input one changes delayed 0.0 to 3600.0 s, default zero
// [R04] only those three inputs are delayed; others pass straight through
// [R05] each digital input polarity digit: 0 high active, 1 low active
// [R06] selector a digits: forward, reverse, input one, two, three
// [R07] selector b units digit sets polarity of input four
// [R08] wiring makes inputs valid by grounding, invalid when open; code does so only at polarity digit 1, at 0 an open input reads active
// [R09] collector function defaults to code 0, relay to code 2
// [R10] code 0 always off; code 1 on while running, even at zero frequency
// [R11] code 2 on when stopped by a fault
// [R12] code 5 on running at zero frequency, off when stopped
// [R13] code 6 on above motor overload pre-warning threshold
// [R14] code 7 on ten seconds before drive overload action
// [R15] code 8 set count reached; code 9 designated count reached
// [R16] code 10 on when actual length exceeds setpoint
// [R17] code 11 gives one 250 ms pulse per sequence cycle done
// [R18] code 12 on when accumulated running time exceeds threshold
// [R19] code 13 on when set frequency outside limit and output reached it
// [R20] code 14 on when torque limit hit and stall protection entered
// [R21] code 15 on when circuits stable, no fault, ready to run
// [R22] code 16 on while first analog channel exceeds second
// [R23] delays timed from 0.1 s tick; reverted changes never propagate
// [R24] reserved or unknown codes keep the output off
`timescale 1ns/1ps
`default_nettype none

module dtio_top
  import dtio_pkg::*;
#(
  parameter int unsigned TICK_CNT  = TICK_CYCLES,
  parameter int unsigned PULSE_CNT = PULSE_CYCLES
) (
  // clock and reset
  input  wire logic                  sys_clk_i,
  input  wire logic                  rst_i,
  // apb slave
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [7:0]            paddr_i,
  input  wire logic [31:0]           pwdata_i,
  output logic      [31:0]           prdata_o,
  output logic                       pready_o,
  output logic                       pslverr_o,
  // terminal pins, raw levels
  input  wire logic [NUM_DIN-1:0]    din_pins_i,
  // analog channels, already scaled
  input  wire dtio_analog_type       analog_voltage_input_i,
  input  wire dtio_analog_type       analog_current_input_i,
  input  wire dtio_analog_type       analog_third_input_i,
  input  wire logic [15:0]           min_point_voltage_i,
  input  wire logic [15:0]           min_point_current_i,
  input  wire logic [15:0]           min_point_third_i,
  input  wire logic [15:0]           first_analog_channel_i,
  input  wire logic [15:0]           second_analog_channel_i,
  // drive state
  input  wire dtio_state_type        drive_state_i,
  // conditioned outputs
  output logic [NUM_DIN-1:0]         din_active_o,
  output logic [15:0]                voltage_setting_o,
  output logic [15:0]                current_setting_o,
  output logic [15:0]                third_setting_o,
  output logic                       open_collector_output_o,
  output logic                       relay_contact_output_o
);

  localparam int unsigned TW = $clog2(TICK_CNT + 1);
  localparam int unsigned PW = $clog2(PULSE_CNT + 1);

  // registers
  logic [2:0]         below_min_policy_select_reg;
  logic [15:0]        delay_reg [3];
  logic [4:0]         polarity_select_a_reg;
  logic               polarity_select_b_reg;
  logic [5:0]         collector_output_function_reg;
  logic [5:0]         relay_output_function_reg;

  // apb decode
  wire acc_phase = psel_i && penable_i;
  wire wr_en     = acc_phase && pwrite_i;
  wire sel_bmin  = paddr_i == OFS_BELOW_MIN;
  wire sel_fwd   = paddr_i == OFS_FWD_DELAY;
  wire sel_rev   = paddr_i == OFS_REV_DELAY;
  wire sel_in1   = paddr_i == OFS_IN1_DELAY;
  wire sel_pola  = paddr_i == OFS_POL_A;
  wire sel_polb  = paddr_i == OFS_POL_B;
  wire sel_coll  = paddr_i == OFS_COLL_FUNC;
  wire sel_rel   = paddr_i == OFS_RELAY_FUNC;
  wire sel_ist   = paddr_i == OFS_IN_STATUS;
  wire sel_ost   = paddr_i == OFS_OUT_STATUS;
  wire mapped    = sel_bmin || sel_fwd || sel_rev || sel_in1 || sel_pola
                || sel_polb || sel_coll || sel_rel || sel_ist || sel_ost;
  // delays beyond 3600.0 s are clamped so a timer never runs past range
  wire [15:0] wdelay = (pwdata_i[15:0] > 16'(DELAY_MAX_TENTHS))
                     ? 16'(DELAY_MAX_TENTHS) : pwdata_i[15:0];

  assign pready_o  = 1'b1;
  assign pslverr_o = acc_phase && !mapped;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      below_min_policy_select_reg   <= RST_BELOW_MIN; // R02
      delay_reg[0]                  <= RST_DELAY; // R03
      delay_reg[1]                  <= RST_DELAY;
      delay_reg[2]                  <= RST_DELAY;
      polarity_select_a_reg         <= RST_POLARITY[4:0]; // R05
      polarity_select_b_reg         <= RST_POLARITY[5];
      collector_output_function_reg <= RST_COLL_FUNC; // R09
      relay_output_function_reg     <= RST_RELAY_FUNC; // R09
    end else if (wr_en) begin
      if (sel_bmin) begin
        below_min_policy_select_reg <= pwdata_i[2:0]; // R02
      end
      if (sel_fwd) begin
        delay_reg[0] <= wdelay;
      end
      if (sel_rev) begin
        delay_reg[1] <= wdelay;
      end
      if (sel_in1) begin
        delay_reg[2] <= wdelay;
      end
      if (sel_pola) begin
        polarity_select_a_reg <= pwdata_i[4:0]; // R06
      end
      if (sel_polb) begin
        polarity_select_b_reg <= pwdata_i[0]; // R07
      end
      if (sel_coll) begin
        collector_output_function_reg <= pwdata_i[5:0];
      end
      if (sel_rel) begin
        relay_output_function_reg <= pwdata_i[5:0];
      end
    end
  end

  // analog below-minimum policy
  function automatic logic [15:0] below_min_sel(input dtio_analog_type a,
                                                input logic [15:0] minpt,
                                                input logic zero_sel);
    if (!a.below_min) begin
      return a.value;
    end else if (zero_sel) begin
      return 16'h0000;
    end
    return minpt;
  endfunction

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      voltage_setting_o <= 16'h0000;
      current_setting_o <= 16'h0000;
      third_setting_o   <= 16'h0000;
    end else begin
      voltage_setting_o <= below_min_sel(analog_voltage_input_i, min_point_voltage_i,
                                         below_min_policy_select_reg[0]); // R01
      current_setting_o <= below_min_sel(analog_current_input_i, min_point_current_i,
                                         below_min_policy_select_reg[1]); // R01
      third_setting_o   <= below_min_sel(analog_third_input_i, min_point_third_i,
                                         below_min_policy_select_reg[2]); // R01
    end
  end

  // pin synchroniser
  logic [NUM_DIN-1:0] sync1_reg;
  logic [NUM_DIN-1:0] sync2_reg;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= din_pins_i;
      sync2_reg <= sync1_reg;
    end
  end

  // polarity: a grounded terminal reads low at the pin
  wire [NUM_DIN-1:0] pol_vec = {polarity_select_b_reg, polarity_select_a_reg}; // R06 R07
  wire [NUM_DIN-1:0] din_level = sync2_reg ^ pol_vec; // R05 R08

  // 0.1 s tick
  logic [TW-1:0] tick_cnt_reg;
  wire           tick = tick_cnt_reg == TW'(TICK_CNT - 1);
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + TW'(1); // R23
    end
  end

  // change delay for forward, reverse and input one
  wire  [2:0]  held;
  wire  [2:0]  dly_in = {din_level[BIT_IN1], din_level[BIT_REV], din_level[BIT_FWD]};

  // each timer owns its flops, so no variable has two writers
  for (genvar g = 0; g < 3; g++) begin : g_dly
    logic        held_reg;
    logic [15:0] dcnt_reg;
    wire         differs = dly_in[g] != held_reg;
    assign held[g] = held_reg;
    always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
        held_reg <= 1'b0;
        dcnt_reg <= 16'h0000;
      end else if (!differs) begin
        dcnt_reg <= 16'h0000; // R23
      end else if (dcnt_reg >= delay_reg[g]) begin
        held_reg <= dly_in[g]; // R03
        dcnt_reg <= 16'h0000;
      end else if (tick) begin
        dcnt_reg <= dcnt_reg + 16'h0001; // R23
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      din_active_o <= '0;
    end else begin
      din_active_o <= {din_level[BIT_IN4], din_level[BIT_IN3], din_level[BIT_IN2],
                       held[2], held[1], held[0]}; // R04
    end
  end

  // sequence completion pulse stretcher
  logic [PW-1:0] pulse_cnt_reg;
  logic          seq_done_d_reg;
  wire           seq_rise = drive_state_i.seq_cycle_done && !seq_done_d_reg;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pulse_cnt_reg  <= '0;
      seq_done_d_reg <= 1'b0;
    end else begin
      seq_done_d_reg <= drive_state_i.seq_cycle_done;
      if (seq_rise) begin
        pulse_cnt_reg <= PW'(PULSE_CNT); // R17
      end else if (pulse_cnt_reg != '0) begin
        pulse_cnt_reg <= pulse_cnt_reg - PW'(1);
      end
    end
  end
  wire seq_pulse = pulse_cnt_reg != '0;

  // condition per function code
  function automatic logic func_sel(input logic [5:0] code,
                                    input dtio_state_type s,
                                    input logic pulse,
                                    input logic ch_gt);
    case (code)
      FN_RUNNING:    return s.running; // R10
      FN_FAULT_STOP: return s.fault_stop; // R11
      FN_ZERO_SPEED: return s.running && s.zero_freq; // R12
      FN_MOTOR_OLW:  return s.motor_ol_warn; // R13
      FN_DRIVE_OLW:  return s.drive_ol_warn; // R14
      FN_SET_COUNT:  return s.set_count_hit; // R15
      FN_DES_COUNT:  return s.des_count_hit; // R15
      FN_LENGTH:     return s.length_over; // R16
      FN_SEQ_DONE:   return pulse; // R17
      FN_RUN_TIME:   return s.run_time_over; // R18
      FN_FREQ_LIMIT: return s.set_freq_out && s.out_freq_at_lim; // R19
      FN_TORQUE_LIM: return s.torque_lim_stall; // R20
      FN_READY:      return s.ready && !s.fault_stop; // R21
      FN_CH1_GT_CH2: return ch_gt; // R22
      default:       return 1'b0; // R10 R24
    endcase
  endfunction

  wire ch_gt = first_analog_channel_i > second_analog_channel_i; // R22

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      open_collector_output_o <= 1'b0;
      relay_contact_output_o  <= 1'b0;
    end else begin
      open_collector_output_o <= func_sel(collector_output_function_reg, drive_state_i,
                                          seq_pulse, ch_gt);
      relay_contact_output_o  <= func_sel(relay_output_function_reg, drive_state_i,
                                          seq_pulse, ch_gt);
    end
  end

  // read mux
  always_comb begin
    prdata_o = 32'h0000_0000;
    if (sel_bmin) begin
      prdata_o = {29'h0, below_min_policy_select_reg};
    end else if (sel_fwd) begin
      prdata_o = {16'h0, delay_reg[0]};
    end else if (sel_rev) begin
      prdata_o = {16'h0, delay_reg[1]};
    end else if (sel_in1) begin
      prdata_o = {16'h0, delay_reg[2]};
    end else if (sel_pola) begin
      prdata_o = {27'h0, polarity_select_a_reg};
    end else if (sel_polb) begin
      prdata_o = {31'h0, polarity_select_b_reg};
    end else if (sel_coll) begin
      prdata_o = {26'h0, collector_output_function_reg};
    end else if (sel_rel) begin
      prdata_o = {26'h0, relay_output_function_reg};
    end else if (sel_ist) begin
      prdata_o = {26'h0, din_active_o};
    end else if (sel_ost) begin
      prdata_o = {30'h0, relay_contact_output_o, open_collector_output_o};
    end
  end

endmodule

`default_nettype wire

// [verilog/dtio_pkg.sv]
// dtio_pkg: register map, field layout, reset values and timing counts for the
// drive terminal conditioning block; assumes a 100 MHz system clock
package dtio_pkg;

  localparam int unsigned CLK_HZ            = 100_000_000;
  localparam int unsigned TICK_MS           = 100;
  localparam int unsigned TICK_CYCLES       = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned PULSE_MS          = 250;
  localparam int unsigned PULSE_CYCLES      = CLK_HZ / 1000 * PULSE_MS;
  localparam int unsigned DELAY_MAX_TENTHS  = 36000;

  // register byte offsets
  localparam logic [7:0] OFS_BELOW_MIN   = 8'h00;
  localparam logic [7:0] OFS_FWD_DELAY   = 8'h04;
  localparam logic [7:0] OFS_REV_DELAY   = 8'h08;
  localparam logic [7:0] OFS_IN1_DELAY   = 8'h0C;
  localparam logic [7:0] OFS_POL_A       = 8'h10;
  localparam logic [7:0] OFS_POL_B       = 8'h14;
  localparam logic [7:0] OFS_COLL_FUNC   = 8'h18;
  localparam logic [7:0] OFS_RELAY_FUNC  = 8'h1C;
  localparam logic [7:0] OFS_IN_STATUS   = 8'h20;
  localparam logic [7:0] OFS_OUT_STATUS  = 8'h24;

  // reset values
  localparam logic [2:0]  RST_BELOW_MIN  = 3'h0;
  localparam logic [15:0] RST_DELAY      = 16'h0000;
  localparam logic [6:0]  RST_POLARITY   = 7'h00;
  localparam logic [5:0]  RST_COLL_FUNC  = 6'h00;
  localparam logic [5:0]  RST_RELAY_FUNC = 6'h02;

  // digital input bit positions
  localparam int unsigned BIT_FWD = 0;
  localparam int unsigned BIT_REV = 1;
  localparam int unsigned BIT_IN1 = 2;
  localparam int unsigned BIT_IN2 = 3;
  localparam int unsigned BIT_IN3 = 4;
  localparam int unsigned BIT_IN4 = 5;
  localparam int unsigned NUM_DIN = 6;

  typedef enum logic [5:0] {
    FN_NONE        = 6'h00,
    FN_RUNNING     = 6'h01,
    FN_FAULT_STOP  = 6'h02,
    FN_ZERO_SPEED  = 6'h05,
    FN_MOTOR_OLW   = 6'h06,
    FN_DRIVE_OLW   = 6'h07,
    FN_SET_COUNT   = 6'h08,
    FN_DES_COUNT   = 6'h09,
    FN_LENGTH      = 6'h0A,
    FN_SEQ_DONE    = 6'h0B,
    FN_RUN_TIME    = 6'h0C,
    FN_FREQ_LIMIT  = 6'h0D,
    FN_TORQUE_LIM  = 6'h0E,
    FN_READY       = 6'h0F,
    FN_CH1_GT_CH2  = 6'h10
  } dtio_func_type;

  // drive state flags from the rest of the controller
  typedef struct packed {
    logic running;
    logic zero_freq;
    logic fault_stop;
    logic motor_ol_warn;
    logic drive_ol_warn;
    logic set_count_hit;
    logic des_count_hit;
    logic length_over;
    logic seq_cycle_done;
    logic run_time_over;
    logic set_freq_out;
    logic out_freq_at_lim;
    logic torque_lim_stall;
    logic ready;
  } dtio_state_type;

  typedef struct packed {
    logic [15:0] value;
    logic        below_min;
  } dtio_analog_type;

endpackage

// [sim/dtio_monitor.sv]
// dtio_monitor: port-level checks of the terminal block
// assumes zero-wait apb writes that land when psel and penable are high
`timescale 1ns/1ps
`default_nettype none

module dtio_monitor
  import dtio_pkg::*;
#(
  parameter int unsigned PULSE_CNT = PULSE_CYCLES
) (
  // clock, reset and apb
  input wire logic               sys_clk_i,
  input wire logic               rst_i,
  input wire logic               psel_i,
  input wire logic               penable_i,
  input wire logic               pwrite_i,
  input wire logic [7:0]         paddr_i,
  input wire logic [31:0]        pwdata_i,
  // terminal and drive inputs
  input wire logic [NUM_DIN-1:0] din_pins_i,
  input wire dtio_analog_type    analog_voltage_input_i,
  input wire dtio_analog_type    analog_third_input_i,
  input wire logic [15:0]        min_point_voltage_i,
  input wire logic [15:0]        first_analog_channel_i,
  input wire logic [15:0]        second_analog_channel_i,
  input wire dtio_state_type     drive_state_i,
  // conditioned outputs
  input wire logic [NUM_DIN-1:0] din_active_o,
  input wire logic [15:0]        voltage_setting_o,
  input wire logic [15:0]        third_setting_o,
  input wire logic               open_collector_output_o,
  input wire logic               relay_contact_output_o
);
  logic [4:0]  pola_reg;
  logic        polb_reg;
  logic [2:0]  bmin_reg;
  logic [5:0]  cfn_reg;
  logic [5:0]  rfn_reg;
  logic [2:0]  live_reg;
  logic [31:0] high_reg;
  // shadow registers, since only ports are visible here
  wire wr_hit = psel_i && penable_i && pwrite_i;
  wire ch_gt  = first_analog_channel_i > second_analog_channel_i;
  wire rsvd   = (cfn_reg inside {6'h03, 6'h04}) || (cfn_reg > 6'h10);

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pola_reg <= 5'h00;
      polb_reg <= 1'b0;
      bmin_reg <= 3'h0;
      cfn_reg  <= 6'h00;
      rfn_reg  <= 6'h02;
      live_reg <= 3'h0;
      high_reg <= 32'h0;
    end else begin
      if (wr_hit && paddr_i == OFS_POL_A) pola_reg <= pwdata_i[4:0];
      if (wr_hit && paddr_i == OFS_POL_B) polb_reg <= pwdata_i[0];
      if (wr_hit && paddr_i == OFS_BELOW_MIN) bmin_reg <= pwdata_i[2:0];
      if (wr_hit && paddr_i == OFS_COLL_FUNC) cfn_reg <= pwdata_i[5:0];
      if (wr_hit && paddr_i == OFS_RELAY_FUNC) rfn_reg <= pwdata_i[5:0];
      // synchroniser is flushed by reset, so wait before trusting levels
      if (live_reg != 3'h7) live_reg <= live_reg + 3'h1;
      high_reg <= open_collector_output_o ? high_reg + 32'h1 : 32'h0;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  AST_CODE0: assert property (cfn_reg == 6'h00 |=> !open_collector_output_o)
    else $error("collector on with code 0");
  AST_RUN: assert property (cfn_reg == 6'h01 |=> open_collector_output_o == $past(drive_state_i.running))
    else $error("collector does not follow running");
  AST_FAULT: assert property (rfn_reg == 6'h02 |=> relay_contact_output_o == $past(drive_state_i.fault_stop))
    else $error("relay does not follow fault stop");
  AST_ZERO: assert property (cfn_reg == 6'h05 && !drive_state_i.running |=> !open_collector_output_o)
    else $error("zero speed output on while stopped");
  AST_GT: assert property (cfn_reg == 6'h10 |=> open_collector_output_o == $past(ch_gt))
    else $error("channel compare output wrong");
  AST_RSVD: assert property (rsvd |=> !open_collector_output_o)
    else $error("reserved code drives output");
  AST_PSTART: assert property (cfn_reg == 6'h0B && $rose(drive_state_i.seq_cycle_done) |-> ##[1:3] open_collector_output_o)
    else $error("sequence pulse missing");
  AST_PWIDTH: assert property (cfn_reg == 6'h0B && $fell(open_collector_output_o) |-> high_reg == PULSE_CNT)
    else $error("sequence pulse width wrong");
  AST_VZERO: assert property (bmin_reg[0] && analog_voltage_input_i.below_min |=> voltage_setting_o == 16'h0000)
    else $error("voltage below minimum not zero");
  AST_VMIN: assert property (!bmin_reg[0] && analog_voltage_input_i.below_min |=> voltage_setting_o == $past(min_point_voltage_i))
    else $error("voltage below minimum not min point");
  AST_TZERO: assert property (bmin_reg[2] && analog_third_input_i.below_min |=> third_setting_o == 16'h0000)
    else $error("third input policy digit wrong");
  AST_DIN3: assert property ((live_reg == 3'h7 && $stable(din_pins_i[3]) && $stable(pola_reg[3]))[*5] |-> din_active_o[3] == (din_pins_i[3] ^ pola_reg[3]))
    else $error("input two level wrong");
  AST_DIN5: assert property ((live_reg == 3'h7 && $stable(din_pins_i[5]) && $stable(polb_reg))[*5] |-> din_active_o[5] == (din_pins_i[5] ^ polb_reg))
    else $error("input four level wrong");
endmodule

bind dtio_top dtio_monitor #(.PULSE_CNT(PULSE_CNT)) u_mon (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .din_pins_i(din_pins_i),
  .analog_voltage_input_i(analog_voltage_input_i), .analog_third_input_i(analog_third_input_i),
  .min_point_voltage_i(min_point_voltage_i), .first_analog_channel_i(first_analog_channel_i),
  .second_analog_channel_i(second_analog_channel_i), .drive_state_i(drive_state_i),
  .din_active_o(din_active_o), .voltage_setting_o(voltage_setting_o),
  .third_setting_o(third_setting_o), .open_collector_output_o(open_collector_output_o),
  .relay_contact_output_o(relay_contact_output_o)
);

`default_nettype wire

// [sim/dtio_wiring.sv]
// dtio_wiring: field switches on the digital input terminals
// assumes a pull-up on every terminal inside the drive
`timescale 1ns/1ps
`default_nettype none

module dtio_wiring
  import dtio_pkg::*;
(
  // contact state, high when closed
  input  wire logic [NUM_DIN-1:0] closed_i,
  // terminal levels
  output logic      [NUM_DIN-1:0] pins_o
);
  // closed contact grounds the terminal, open one floats to the pull-up
  assign pins_o = ~closed_i;
endmodule

`default_nettype wire

// [sim/tb.sv]
// tb: apb, terminal and output function tests of dtio_top
// assumes shortened tick and pulse counts set at the instance
`timescale 1ns/1ps
`default_nettype none

module tb
  import dtio_pkg::*;
;
  localparam int unsigned PULSE = 20;
  logic            sys_clk_i = 1'b0;
  logic            rst_i = 1'b1;
  logic            psel = 1'b0;
  logic            penable = 1'b0;
  logic            pwrite = 1'b0;
  logic [7:0]      paddr = 8'h00;
  logic [31:0]     pwdata = 32'h0;
  logic [5:0]      closed = 6'h00;
  dtio_analog_type av = 17'h00000;
  dtio_analog_type ac = 17'h00000;
  dtio_analog_type at = 17'h00000;
  logic [15:0]     ch1 = 16'h0000;
  logic [15:0]     ch2 = 16'h0000;
  dtio_state_type  st = 14'h0000;
  wire logic [31:0] prdata;
  wire logic        pready, pslverr, oc, rly;
  wire logic [5:0]  pins, din;
  wire logic [15:0] vset, cset, tset;
  int               sel = 0;
  wire logic        ov = (sel != 0) ? rly : oc;
  int               num_errors = 0;
  int               samples_checked = 0;
  int               n;
  logic [31:0] dflt [8] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h2};
  logic [5:0]  fcode [12] = '{6'h01, 6'h02, 6'h05, 6'h06, 6'h07, 6'h08, 6'h09, 6'h0A,
                              6'h0C, 6'h0D, 6'h0E, 6'h0F};
  logic [13:0] on_m [12] = '{14'h2000, 14'h0800, 14'h3000, 14'h0400, 14'h0200, 14'h0100,
                             14'h0080, 14'h0040, 14'h0010, 14'h000C, 14'h0002, 14'h0001};
  logic [13:0] off_m [12] = '{14'h1000, 14'h2000, 14'h1000, 14'h0000, 14'h0000, 14'h0000,
                              14'h0000, 14'h0000, 14'h0000, 14'h0008, 14'h0000, 14'h0801};
  logic [5:0]  rsv [5] = '{6'h00, 6'h03, 6'h04, 6'h11, 6'h3F};

  always #5 sys_clk_i = ~sys_clk_i;

  dtio_wiring wiring (.closed_i(closed), .pins_o(pins));

  dtio_top #(.TICK_CNT(10), .PULSE_CNT(PULSE)) dut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .din_pins_i(pins),
    .analog_voltage_input_i(av), .analog_current_input_i(ac), .analog_third_input_i(at),
    .min_point_voltage_i(16'h0AAA), .min_point_current_i(16'h0BBB),
    .min_point_third_i(16'h0CCC), .first_analog_channel_i(ch1),
    .second_analog_channel_i(ch2), .drive_state_i(st), .din_active_o(din),
    .voltage_setting_o(vset), .current_setting_o(cset), .third_setting_o(tset),
    .open_collector_output_o(oc), .relay_contact_output_o(rly)
  );

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk_i);
    penable <= 1'b1;
    @(posedge sys_clk_i);
    while (pready !== 1'b1) @(posedge sys_clk_i);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(nm, x, q);
    chk("slverr", {31'h0, xe}, {31'h0, e});
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk_i);
    num_errors++;
    finish_test();
  end

  initial begin
    repeat (10) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 8; i++) rd("default", 8'(4 * i), dflt[i], 1'b0);
    wr(8'h30, 32'hFFFF_FFFF);
    rd("unmapped", 8'h30, 32'h0, 1'b1);
    // delayed forward input next to undelayed input two
    wr(OFS_FWD_DELAY, 32'h3);
    chk("fwd idle", 32'h1, {31'h0, din[0]});
    closed <= 6'h09;
    repeat (20) @(posedge sys_clk_i);
    chk("fwd early", 32'h1, {31'h0, din[0]});
    chk("in2 direct", 32'h0, {31'h0, din[3]});
    repeat (30) @(posedge sys_clk_i);
    chk("fwd late", 32'h0, {31'h0, din[0]});
    closed[0] <= 1'b0;
    repeat (10) @(posedge sys_clk_i);
    closed[0] <= 1'b1;
    repeat (60) @(posedge sys_clk_i);
    chk("fwd glitch", 32'h0, {31'h0, din[0]});
    wr(OFS_FWD_DELAY, 32'hFFFF);
    rd("delay clamp", OFS_FWD_DELAY, 32'h8CA0, 1'b0);
    // low-active on input two, three and four
    wr(OFS_POL_A, 32'h18);
    wr(OFS_POL_B, 32'h1);
    closed <= 6'h19;
    repeat (8) @(posedge sys_clk_i);
    chk("polarity", 32'h1E, {26'h0, din});
    rd("in status", OFS_IN_STATUS, 32'h1E, 1'b0);
    // below minimum policy per digit
    av <= {16'h1234, 1'b1};
    ac <= {16'h2222, 1'b1};
    at <= {16'h3333, 1'b0};
    wr(OFS_BELOW_MIN, 32'h2);
    repeat (2) @(posedge sys_clk_i);
    chk("volt", 32'h0AAA, {16'h0, vset});
    chk("curr", 32'h0, {16'h0, cset});
    chk("third", 32'h3333, {16'h0, tset});
    at <= {16'h3333, 1'b1};
    wr(OFS_BELOW_MIN, 32'h5);
    repeat (2) @(posedge sys_clk_i);
    chk("volt", 32'h0, {16'h0, vset});
    chk("curr", 32'h0BBB, {16'h0, cset});
    chk("third", 32'h0, {16'h0, tset});
    // function codes on both outputs
    for (sel = 0; sel < 2; sel++) begin
      for (int i = 0; i < 12; i++) begin
        wr(sel ? OFS_RELAY_FUNC : OFS_COLL_FUNC, {26'h0, fcode[i]});
        st <= on_m[i];
        repeat (3) @(posedge sys_clk_i);
        chk("code on", 32'h1, {31'h0, ov});
        st <= off_m[i];
        repeat (3) @(posedge sys_clk_i);
        chk("code off", 32'h0, {31'h0, ov});
      end
      st <= 14'h3FFF;
      for (int i = 0; i < 5; i++) begin
        wr(sel ? OFS_RELAY_FUNC : OFS_COLL_FUNC, {26'h0, rsv[i]});
        repeat (3) @(posedge sys_clk_i);
        chk("reserved", 32'h0, {31'h0, ov});
      end
      st <= 14'h0000;
      wr(sel ? OFS_RELAY_FUNC : OFS_COLL_FUNC, 32'h10);
      ch1 <= 16'h0101;
      ch2 <= 16'h0100;
      repeat (3) @(posedge sys_clk_i);
      chk("ch gt", 32'h1, {31'h0, ov});
      rd("out status", OFS_OUT_STATUS, sel ? 32'h2 : 32'h1, 1'b0);
      ch2 <= 16'h0101;
      repeat (3) @(posedge sys_clk_i);
      chk("ch eq", 32'h0, {31'h0, ov});
      wr(sel ? OFS_RELAY_FUNC : OFS_COLL_FUNC, 32'h0B);
      st <= 14'h0020;
      n = 0;
      repeat (60) begin
        @(negedge sys_clk_i);
        if (ov === 1'b1) n++;
      end
      chk("pulse len", PULSE, n);
      @(posedge sys_clk_i);
      st <= 14'h0000;
    end
    finish_test();
  end
endmodule

`default_nettype wire
